// >>> dv/dfa_mem_model.sv
/*
 * Byte memory standing on the channel's memory port.
 * Assumes the port is on clk; slow adds two wait states.
 */
`timescale 1ns/1ps
`default_nettype none

module dfa_mem_model (
    // Clock and pacing
    input wire logic clk,
    input wire logic slow,
    // Memory port
    input wire dfa_pkg::dfa_mem_req_type mem_req,
    input wire logic mem_valid,
    output logic mem_ready,
    output logic [15:0] mem_rdata
);
    import dfa_pkg::*;

    logic [7:0] mem [0:255];
    logic [1:0] wait_cnt = 2'h0;
    logic [15:0] last = 16'h0000;
    wire logic [7:0] lo = mem_req.addr[7:0];
    wire logic [7:0] hi = 8'(lo + 8'h01);
    wire logic rd_now = mem_valid && !mem_req.write;

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
    end

    assign mem_ready = mem_valid && (wait_cnt == (slow ? 2'h2 : 2'h0));
    // Idle data inverted so a stale read cannot pass
    assign mem_rdata = rd_now ? {mem[hi], mem[lo]} : ~last;

    ////////////////////////////////////////////////////////////////
    // write lands only on accepted unit
    always @(posedge clk) begin
        wait_cnt <= (mem_valid && !mem_ready) ? 2'(wait_cnt + 2'h1) : 2'h0;
        if (mem_ready && mem_req.write) begin
            mem[lo] <= mem_req.wdata[7:0];
            if (mem_req.word) begin
                mem[hi] <= mem_req.wdata[15:8];
            end
        end
        if (mem_ready && rd_now) begin
            last <= mem_rdata;
        end
    end
endmodule

`default_nettype wire

// >>> dv/dma_full_address_channel_test.sv
/*
 * Self-checking bench for the full address channel over APB.
 * Assumes zero-wait APB and the byte memory model on the far side.
 */
`timescale 1ns/1ps
`default_nettype none

module dma_full_address_channel_test;
    import dfa_pkg::*;

    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, standby = 0, slow = 0;
    logic ext_transfer_request = 1;
    logic nmi = 0;
    logic [3:0] timer_pulse = 4'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, pslv, mem_valid, mem_ready, bus_hold, irq;
    logic [15:0] mem_rdata;
    dfa_mem_req_type mem_req;
    int bad_count = 0, num_checks = 0;

    always #5 clk = ~clk;

    dfa_channel i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .standby(standby), .nmi(nmi), .ext_transfer_request(ext_transfer_request),
        .timer_event(timer_pulse), .mem_req(mem_req), .mem_valid(mem_valid), .mem_ready(mem_ready),
        .mem_rdata(mem_rdata), .bus_hold(bus_hold), .transfer_end_irq(irq));
    dfa_mem_model i_mem (.clk(clk), .slow(slow), .mem_req(mem_req), .mem_valid(mem_valid),
        .mem_ready(mem_ready), .mem_rdata(mem_rdata));

    ////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_mem(input logic [7:0] a, input logic [7:0] exp);
        check({24'h00_0000, i_mem.mem[a]}, {24'h00_0000, exp});
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        // Only the watchdog ends a stuck access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        pslv = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task do_reset;
        rst <= 1;
        repeat (10) @(posedge clk);
        rst <= 0;
    endtask

    task cfg(input logic [15:0] cnt, input logic [23:0] s, input logic [23:0] dd,
             input logic [7:0] cb, input logic [7:0] ca);
        apb(1, OFS_COUNT_A, {16'h0000, cnt});
        apb(1, OFS_SRC_ADDR, {8'h00, s});
        apb(1, OFS_DST_ADDR, {8'h00, dd});
        apb(0, OFS_CTRL_B, 32'h0000_0000);
        apb(1, OFS_CTRL_B, {24'h00_0000, cb});
        apb(0, OFS_CTRL_A, 32'h0000_0000);
        apb(1, OFS_CTRL_A, {24'h00_0000, ca});
    endtask

    // Polls control A until the enable falls
    task wait_done;
        int n;
        n = 0;
        do begin
            apb(0, OFS_CTRL_A, 32'h0000_0000);
            n++;
        end while (rd[7] !== 1'b0 && n < 60);
        // Poll limit running out counts as a mismatch
        if (rd[7] !== 1'b0) begin
            bad_count++;
        end
    endtask

    function automatic logic [7:0] pre(input int i);
        return 8'(i) ^ 8'hA5;
    endfunction

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        report_and_stop;
    end

    initial begin
        do_reset;
        apb(0, OFS_CTRL_A, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(0, 8'h1C, 32'h0000_0000);
        check({31'h0, pslv}, 32'h0000_0001);
        // Burst, bytes, both addresses up
        cfg(16'h0003, 24'h00_0010, 24'h00_0040, 8'h90, 8'h9E);
        wait_done;
        check(rd, 32'h0000_001E);
        check({31'h0, irq}, 32'h0000_0001);
        apb(0, OFS_COUNT_A, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(0, OFS_SRC_ADDR, 32'h0000_0000);
        check(rd, 32'hFF00_0013);
        apb(0, OFS_DST_ADDR, 32'h0000_0000);
        check(rd, 32'hFF00_0043);
        for (int i = 0; i < 3; i++) begin
            chk_mem(8'(8'h40 + i), pre(16 + i));
        end
        chk_mem(8'h43, pre(8'h43));
        // Cycle steal, words, source down, destination fixed, slow memory
        do_reset;
        slow <= 1;
        cfg(16'h0002, 24'h00_0030, 24'h00_0060, 8'h82, 8'hF6);
        wait_done;
        check({31'h0, irq}, 32'h0000_0000);
        apb(0, OFS_SRC_ADDR, 32'h0000_0000);
        check(rd, 32'hFF00_002C);
        apb(0, OFS_DST_ADDR, 32'h0000_0000);
        check(rd, 32'hFF00_0060);
        chk_mem(8'h60, pre(8'h2E));
        chk_mem(8'h61, pre(8'h2F));
        // Reserved bit, standby and reset
        apb(1, OFS_COUNT_B, 32'h0000_1234);
        apb(1, OFS_CTRL_B, 32'h0000_0040);
        apb(0, OFS_CTRL_B, 32'h0000_0000);
        check(rd, 32'h0000_0040);
        standby <= 1;
        @(posedge clk);
        standby <= 0;
        apb(0, OFS_CTRL_B, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        do_reset;
        apb(0, OFS_COUNT_B, 32'h0000_0000);
        check(rd, 32'h0000_1234);
        // Falling edge request; count B left nonzero
        slow <= 0;
        cfg(16'h0001, 24'h00_0050, 24'h00_0070, 8'h96, 8'h96);
        repeat (20) @(posedge clk);
        apb(0, OFS_COUNT_A, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        ext_transfer_request <= 0;
        repeat (5) @(posedge clk);
        ext_transfer_request <= 1;
        wait_done;
        apb(0, OFS_COUNT_A, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        chk_mem(8'h70, pre(8'h50));
        apb(0, OFS_COUNT_B, 32'h0000_0000);
        check(rd, 32'h0000_1234);
        // Low level request, two units
        cfg(16'h0002, 24'h00_00C0, 24'h00_00D0, 8'h97, 8'h96);
        ext_transfer_request <= 0;
        wait_done;
        ext_transfer_request <= 1;
        apb(0, OFS_COUNT_A, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        chk_mem(8'hD1, pre(8'hC1));
        // Burst of eight; NMI lets the unit in flight finish, then suspends
        cfg(16'h0008, 24'h00_00A0, 24'h00_00B0, 8'h90, 8'h96);
        nmi <= 1;
        repeat (8) @(posedge clk);
        nmi <= 0;
        apb(0, OFS_COUNT_A, 32'h0000_0000);
        check(rd, 32'h0000_0007);
        apb(0, OFS_CTRL_B, 32'h0000_0000);
        check(rd, 32'h0000_0010);
        apb(1, OFS_CTRL_B, 32'h0000_0090);
        wait_done;
        check(rd, 32'h0000_0016);
        chk_mem(8'hB7, pre(8'hA7));
        // Block mode on timer 0, two blocks of two, destination is the block area
        apb(1, OFS_COUNT_B, 32'h0000_0002);
        cfg(16'h0202, 24'h00_0080, 24'h00_0090, 8'h90, 8'h97);
        timer_pulse <= 4'h1;
        @(posedge clk);
        timer_pulse <= 4'h0;
        repeat (20) @(posedge clk);
        apb(0, OFS_COUNT_B, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        timer_pulse <= 4'h1;
        @(posedge clk);
        timer_pulse <= 4'h0;
        wait_done;
        apb(0, OFS_COUNT_A, 32'h0000_0000);
        check(rd, 32'h0000_0202);
        apb(0, OFS_DST_ADDR, 32'h0000_0000);
        check(rd, 32'hFF00_0090);
        chk_mem(8'h91, pre(8'h83));
        report_and_stop;
    end
endmodule

`default_nettype wire

// >>> logic/dfa_channel.sv
/*
 * Full address channel pair: APB register slave, activation decode,
 * one-unit memory mover, counters and address stepping.
 * Assumes a memory port on clk that answers mem_valid with mem_ready;
 * the external request and NMI pins are asynchronous.
 */
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module dfa_channel (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System events
    input wire logic standby,
    input wire logic nmi,
    input wire logic ext_transfer_request,
    input wire logic [3:0] timer_event,
    // Memory master
    output dfa_pkg::dfa_mem_req_type mem_req,
    output logic mem_valid,
    input wire logic mem_ready,
    input wire logic [15:0] mem_rdata,
    output logic bus_hold,
    // Interrupt request
    output logic transfer_end_irq
);
    import dfa_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [15:0] transfer_count_a, block_count_b;
    logic [7:0] channel_control_a, channel_control_b;
    logic [23:0] source_address, destination_address, src_base, dst_base;
    dfa_state_type state, next_state;
    dfa_mem_req_type next_mem_req;
    logic next_mem_valid, next_bus_hold;
    logic pending, block_active, armed_a, armed_b;
    logic [2:0] req_sync, nmi_sync;

    function automatic logic [23:0] step_addr(input logic [23:0] a, input logic en,
                                              input logic dir, input logic word);
        logic [23:0] d;
        d = word ? 24'h00_0002 : 24'h00_0001;
        step_addr = !en ? a : (dir ? a - d : a + d);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Request pin idles high; no false edge after reset
            req_sync <= 3'h7;
            nmi_sync <= 3'h0;
        end else begin
            req_sync <= {req_sync[1:0], ext_transfer_request};
            nmi_sync <= {nmi_sync[1:0], nmi};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode

    wire apb_setup = psel & ~penable;
    wire apb_access = psel & penable;
    wire apb_wr = apb_access & pwrite;
    wire apb_rd = apb_access & ~pwrite;
    wire wr_count_a = apb_wr & (paddr == OFS_COUNT_A);
    wire wr_count_b = apb_wr & (paddr == OFS_COUNT_B);
    wire wr_ctrl_a = apb_wr & (paddr == OFS_CTRL_A);
    wire wr_ctrl_b = apb_wr & (paddr == OFS_CTRL_B);
    wire wr_src = apb_wr & (paddr == OFS_SRC_ADDR);
    wire wr_dst = apb_wr & (paddr == OFS_DST_ADDR);
    wire rd_ctrl_a = apb_rd & (paddr == OFS_CTRL_A);
    wire rd_ctrl_b = apb_rd & (paddr == OFS_CTRL_B);
    wire addr_hit = (paddr == OFS_COUNT_A) | (paddr == OFS_COUNT_B) | (paddr == OFS_CTRL_A) |
                    (paddr == OFS_CTRL_B) | (paddr == OFS_SRC_ADDR) | (paddr == OFS_DST_ADDR) |
                    (paddr == OFS_STATUS);
    wire ctrl_clear = standby;

    // RULE_06 full mode gate
    wire full_mode = channel_control_a[CA_FULL_HI] & channel_control_a[CA_FULL_LO];
    // RULE_14 mode select
    wire block_mode = channel_control_a[CA_BLOCK];
    wire unit_word = channel_control_a[CA_SIZE];
    // RULE_07 both enables
    wire chan_enabled = channel_control_a[CA_XFER_EN] & channel_control_b[CB_MASTER_EN] & full_mode;
    wire [2:0] act = channel_control_b[2:0];
    wire req_fall = req_sync[2] & ~req_sync[1];
    wire nmi_rise = nmi_sync[1] & ~nmi_sync[2];

    // RULE_20 normal activation decode
    wire act_burst = ~block_mode & (act == ACT_BURST);
    wire act_auto = act_burst | (~block_mode & (act == ACT_STEAL));
    wire act_level = ~block_mode & (act == ACT_LOW) & ~req_sync[1];
    // RULE_22 block activation decode
    wire act_timer = block_mode & ~act[2] & timer_event[act[1:0]];
    wire act_edge = (act == ACT_FALL) & req_fall;

    wire start_unit = (state == ST_IDLE) & chan_enabled &
                      (act_auto | act_level | pending | block_active);
    wire unit_done = (state == ST_UPDATE);

    ////////////////////////////////////////////////////////////////////////
    // Counter arithmetic

    wire [15:0] count_a_dec = transfer_count_a - 16'h0001;
    wire [7:0] size_dec = transfer_count_a[15:8] - 8'h01;
    wire [15:0] count_b_dec = block_count_b - 16'h0001;
    wire block_end = block_mode & (size_dec == 8'h00);
    // RULE_01 normal end at zero
    // RULE_04 block end at zero
    wire finish = block_mode ? (block_end & (count_b_dec == 16'h0000)) : (count_a_dec == 16'h0000);
    wire hw_clear_en = unit_done & finish;
    // RULE_03 size counter reload
    wire [15:0] next_count_a = ~block_mode ? count_a_dec :
                               block_end ? {transfer_count_a[7:0], transfer_count_a[7:0]} :
                               {size_dec, transfer_count_a[7:0]};

    // RULE_11 byte or word step
    // RULE_12 source step
    wire [23:0] src_step = step_addr(source_address, channel_control_a[CA_SRC_EN],
                                     channel_control_a[CA_SRC_DIR], unit_word);
    // RULE_13 destination step
    wire [23:0] dst_step = step_addr(destination_address, channel_control_b[CB_DST_EN],
                                     channel_control_b[CB_DST_DIR], unit_word);
    // RULE_19 block area restore
    wire [23:0] next_src = (block_end & channel_control_b[CB_SRC_AREA]) ? src_base : src_step;
    wire [23:0] next_dst = (block_end & ~channel_control_b[CB_SRC_AREA]) ? dst_base : dst_step;

    ////////////////////////////////////////////////////////////////////////
    // Counters and addresses, untouched by reset and standby

    // RULE_05 no reset on counters
    always_ff @(posedge clk) begin
        if (wr_count_a) begin
            transfer_count_a <= pwdata[15:0];
        end else if (unit_done) begin
            transfer_count_a <= next_count_a;
        end
        if (wr_count_b) begin
            block_count_b <= pwdata[15:0];
        // RULE_02 count B idle in normal mode
        end else if (unit_done & block_end) begin
            block_count_b <= count_b_dec;
        end
        // RULE_21 source and destination roles
        if (wr_src) begin
            source_address <= pwdata[23:0];
        end else if (unit_done) begin
            source_address <= next_src;
        end
        if (wr_dst) begin
            destination_address <= pwdata[23:0];
        end else if (unit_done) begin
            destination_address <= next_dst;
        end
        if (start_unit & block_mode & ~block_active) begin
            src_base <= source_address;
            dst_base <= destination_address;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    // Software write beats the automatic clear; the clear is then lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            channel_control_a <= CTRL_RESET;
            channel_control_b <= CTRL_RESET;
            armed_a <= 1'b0;
            armed_b <= 1'b0;
        // RULE_15 standby clears controls
        end else if (ctrl_clear) begin
            channel_control_a <= CTRL_RESET;
            channel_control_b <= CTRL_RESET;
            armed_a <= 1'b0;
            armed_b <= 1'b0;
        end else begin
            if (wr_ctrl_a) begin
                // RULE_09 read-then-write arming
                channel_control_a <= {pwdata[7] & (channel_control_a[CA_XFER_EN] | armed_a), pwdata[6:0]};
                armed_a <= 1'b0;
            // RULE_08 automatic enable clear
            end else if (hw_clear_en) begin
                channel_control_a[CA_XFER_EN] <= 1'b0;
            end else if (rd_ctrl_a & ~channel_control_a[CA_XFER_EN]) begin
                armed_a <= 1'b1;
            end
            // RULE_16 NMI drops master enable
            if (nmi_rise) begin
                channel_control_b[CB_MASTER_EN] <= 1'b0;
            end else if (wr_ctrl_b) begin
                // RULE_17 read-then-write arming
                channel_control_b[CB_MASTER_EN] <= pwdata[7] & (channel_control_b[CB_MASTER_EN] | armed_b);
            end
            // RULE_18 reserved bit kept
            if (wr_ctrl_b) begin
                channel_control_b[6:0] <= pwdata[6:0];
                armed_b <= 1'b0;
            end else if (rd_ctrl_b & ~channel_control_b[CB_MASTER_EN]) begin
                armed_b <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Requests, end interrupt

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending <= 1'b0;
            block_active <= 1'b0;
            transfer_end_irq <= 1'b0;
        end else begin
            // RULE_08 refuse while disabled
            if (~channel_control_a[CA_XFER_EN] | ctrl_clear) begin
                pending <= 1'b0;
            end else if (act_edge | act_timer) begin
                pending <= 1'b1;
            end else if (start_unit & ~block_active) begin
                pending <= 1'b0;
            end
            if (~channel_control_a[CA_XFER_EN] | ~block_mode | (unit_done & block_end)) begin
                block_active <= 1'b0;
            end else if (start_unit) begin
                block_active <= 1'b1;
            end
            // RULE_10 end interrupt, set wins
            if (hw_clear_en & channel_control_a[CA_IRQ_EN]) begin
                transfer_end_irq <= 1'b1;
            end else if (ctrl_clear | (wr_ctrl_a & (pwdata[CA_XFER_EN] | ~pwdata[CA_IRQ_EN]))) begin
                transfer_end_irq <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Unit mover

    // RULE_23 read, write, then update
    always_comb begin
        next_state = state;
        next_mem_req = mem_req;
        next_mem_valid = mem_valid;
        unique case (state)
            ST_IDLE: begin
                if (start_unit) begin
                    next_state = ST_READ;
                    next_mem_req = '{addr: source_address, write: 1'b0, word: unit_word, wdata: 16'h0000};
                    next_mem_valid = 1'b1;
                end
            end
            ST_READ: begin
                if (mem_ready) begin
                    next_state = ST_WRITE;
                    next_mem_req = '{addr: destination_address, write: 1'b1, word: unit_word,
                                     wdata: mem_rdata};
                end
            end
            ST_WRITE: begin
                if (mem_ready) begin
                    next_state = ST_UPDATE;
                    next_mem_valid = 1'b0;
                end
            end
            ST_UPDATE: begin
                next_state = ST_IDLE;
            end
        endcase
        // Burst keeps the bus between units; cycle steal lets it go
        next_bus_hold = (next_state != ST_IDLE) | (unit_done & act_burst & ~finish & chan_enabled);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            mem_req <= '0;
            mem_valid <= 1'b0;
            bus_hold <= 1'b0;
        end else begin
            state <= next_state;
            mem_req <= next_mem_req;
            mem_valid <= next_mem_valid;
            bus_hold <= next_bus_hold;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states

    wire [31:0] status_word = {26'h000_0000, block_active, pending, chan_enabled, full_mode, state};
    wire [31:0] rd_mux = (paddr == OFS_COUNT_A) ? {16'h0000, transfer_count_a} :
                         (paddr == OFS_COUNT_B) ? {16'h0000, block_count_b} :
                         (paddr == OFS_CTRL_A) ? {24'h00_0000, channel_control_a} :
                         (paddr == OFS_CTRL_B) ? {24'h00_0000, channel_control_b} :
                         (paddr == OFS_SRC_ADDR) ? {ADDR_PAD, source_address} :
                         (paddr == OFS_DST_ADDR) ? {ADDR_PAD, destination_address} :
                         (paddr == OFS_STATUS) ? status_word : 32'h0000_0000;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (apb_setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= ~addr_hit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_NORMAL_COUNT: assert property (unit_done & ~block_mode & ~wr_count_a |=> // RULE_01
        transfer_count_a == $past(count_a_dec)) else $error("normal count did not drop by one");
    AST_COUNT_B_IDLE: assert property (unit_done & ~block_mode & ~wr_count_b |=> // RULE_02
        $stable(block_count_b)) else $error("count B moved in normal mode");
    AST_BLOCK_RELOAD: assert property (unit_done & block_end & ~wr_count_a |=> // RULE_03
        transfer_count_a[15:8] == $past(transfer_count_a[7:0])) else $error("block size not reloaded");
    AST_BLOCK_COUNT: assert property (unit_done & block_end & ~wr_count_b |=> // RULE_04
        block_count_b == $past(block_count_b) - 16'h0001) else $error("block count did not drop");
    AST_AUTO_CLEAR: assert property (hw_clear_en & ~wr_ctrl_a & ~ctrl_clear |=> // RULE_08
        ~channel_control_a[CA_XFER_EN] ##1 (state == ST_IDLE)) else $error("enable not cleared at end");
    AST_END_IRQ: assert property (hw_clear_en & channel_control_a[CA_IRQ_EN] |=> // RULE_10
        transfer_end_irq) else $error("end interrupt missing");
    AST_NO_START: assert property ((state == ST_IDLE) & ~chan_enabled |=> // RULE_07
        (state == ST_IDLE) & ~mem_valid) else $error("unit started while disabled");
    AST_SRC_STEP: assert property (unit_done & ~block_mode & channel_control_a[CA_SRC_EN] & // RULE_12
        ~channel_control_a[CA_SRC_DIR] & ~wr_src |=>
        source_address == $past(source_address) + (unit_word ? 24'h00_0002 : 24'h00_0001))
        else $error("source step wrong");
    AST_NMI_STOP: assert property (nmi_rise |=> ~channel_control_b[CB_MASTER_EN]) // RULE_16
        else $error("NMI did not drop master enable");
    AST_STANDBY: assert property (standby |=> // RULE_15
        (channel_control_a == CTRL_RESET) && (channel_control_b == CTRL_RESET)) else $error("standby kept controls");
    AST_ORDER: assert property ((state == ST_READ) & mem_ready |=> // RULE_23
        (state == ST_WRITE) & mem_req.write & (mem_req.addr == destination_address))
        else $error("write did not follow read");

    COV_NORMAL_END: cover property (hw_clear_en & ~block_mode);
    COV_BLOCK_END: cover property (unit_done & block_end);
    COV_NMI_SUSPEND: cover property (nmi_rise & (state != ST_IDLE));
    COV_EDGE_START: cover property (act_edge & chan_enabled);

endmodule

`default_nettype wire

// >>> logic/dfa_pkg.sv
/*
 * Shared constants and carrier types for the full address channel pair:
 * register offsets, field positions, reset values, activation codes and
 * the memory request carrier.
 * Assumes an APB master with 8-bit byte addresses and 32-bit data.
 */
// Summary of operation
// RULE_01: Normal mode: count A is a 16-bit counter, minus one per unit, ends at zero.
// RULE_02: Normal mode: count B is ignored and never changes channel behaviour.
// RULE_03: Block mode: upper byte of count A counts the block, reloads from lower byte.
// RULE_04: Block mode: count B counts blocks, minus one per block, ends at zero.
// RULE_05: Both count registers keep their value over reset and standby.
// RULE_06: Full address mode runs only while control A bits 2 and 1 are set.
// RULE_07: Channel runs only with master and transfer enables; auto-request starts at once.
// RULE_08: Transfer enable clears itself at the end; while clear, requests are refused.
// RULE_09: Software reads control A with enable clear before writing the enable as one.
// RULE_10: Clearing transfer enable raises the end interrupt when interrupt enable is set; the code raises it only on the automatic clear at the end.
// RULE_11: Size bit zero moves bytes, one moves 16-bit words.
// RULE_12: Source address holds, or steps up or down by one or two.
// RULE_13: Destination address holds, or steps up or down by one or two.
// RULE_14: Control A bit 0 selects normal mode (zero) or block mode (one).
// RULE_15: Reset and standby clear both control registers to zero.
// RULE_16: Non-maskable interrupt clears master enable; transfer resumes when set again.
// RULE_17: Software reads control B with master enable clear before setting it.
// RULE_18: Control B bit 6 is stored and read back without function.
// RULE_19: Block mode: mode select zero makes destination the block area, one the source.
// RULE_20: Normal activation: 000 burst, 010 cycle steal, 110 falling edge, 111 low level.
// RULE_21: Address register one is the source, address register two the destination.
// RULE_22: Block activation: 000 to 011 timer events, 110 falling edge of request.
// RULE_23: Each unit reads the source, writes the destination, then updates addresses and counts.
package dfa_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_COUNT_A = 8'h00;
    localparam logic [7:0] OFS_COUNT_B = 8'h04;
    localparam logic [7:0] OFS_CTRL_A = 8'h08;
    localparam logic [7:0] OFS_CTRL_B = 8'h0C;
    localparam logic [7:0] OFS_SRC_ADDR = 8'h10;
    localparam logic [7:0] OFS_DST_ADDR = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // Control A fields
    localparam int CA_XFER_EN = 7;
    localparam int CA_SIZE = 6;
    localparam int CA_SRC_DIR = 5;
    localparam int CA_SRC_EN = 4;
    localparam int CA_IRQ_EN = 3;
    localparam int CA_FULL_HI = 2;
    localparam int CA_FULL_LO = 1;
    localparam int CA_BLOCK = 0;

    // Control B fields
    localparam int CB_MASTER_EN = 7;
    localparam int CB_DST_DIR = 5;
    localparam int CB_DST_EN = 4;
    localparam int CB_SRC_AREA = 3;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] ADDR_PAD = 8'hFF;

    // Activation codes
    localparam logic [2:0] ACT_BURST = 3'b000;
    localparam logic [2:0] ACT_STEAL = 3'b010;
    localparam logic [2:0] ACT_FALL = 3'b110;
    localparam logic [2:0] ACT_LOW = 3'b111;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10,
        ST_UPDATE = 2'b11
    } dfa_state_type;

    typedef struct packed {
        logic [23:0] addr;
        logic write;
        logic word;
        logic [15:0] wdata;
    } dfa_mem_req_type;

endpackage
